// ==== hw/pcs_pkg.sv ====
// package: offsets, field positions, reset value and carrier types for the power control register
package pcs_pkg;
    localparam logic [7:0] POWER_CTRL_OFFSET = 8'h0A;
    localparam logic [7:0] POWER_CTRL_RESET  = 8'h7F;
    localparam logic [7:0] POWER_CTRL_USED   = 8'h4F;
    localparam int         CH_COUNT          = 3;
    localparam int         BIT_CH_FIRST      = 0;
    localparam int         BIT_PULSE_SKIP    = 3;
    localparam int         BIT_UVLO_SELECT   = 6;

    // register access request from the management interface
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcs_req_s;

    // controls presented to the converters and the analog monitor
    typedef struct packed {
        logic [CH_COUNT-1:0] chanEnable;
        logic                pulseSkipSelect;
        logic                inputUndervoltageThresholdSelect;
    } pcs_ctrl_s;
endpackage

// ==== hw/pcs_power_control.sv ====
// power control register: channel select on enable rise, pulse skip and uvlo threshold
module pcs_power_control (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 enablePin,
    input  wire pcs_pkg::pcs_req_s    req,
    output logic [7:0]                rdata,
    output logic                      rvalid,
    output pcs_pkg::pcs_ctrl_s        ctrl
);
    // ************************************************************
    // reset release and pin synchronisation
    // ************************************************************
    logic rstMeta;
    logic rstMetaNext;
    logic rstSync;
    logic rstSyncNext;
    logic rstLocal_n;
    logic enSync;

    // release ripples in from the top; the first stage may go metastable,
    // so only the second stage feeds the rest of the block
    always_comb begin
        rstMetaNext = 1'b1;
        rstSyncNext = rstMeta;
    end

    // reset asserts at once, releases after two edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= rstMetaNext;
            rstSync <= rstSyncNext;
        end
    end
    assign rstLocal_n = rstSync;

    pcs_sync uEnSync (
        .clk   (clk),
        .rst_n (rstLocal_n),
        .din   (enablePin),
        .dout  (enSync)
    );

    // ************************************************************
    // register file
    // ************************************************************
    function automatic logic hitsReg(input logic [7:0] a);
        return a == pcs_pkg::POWER_CTRL_OFFSET;
    endfunction

    logic [7:0]         powerControlReg;
    logic [7:0]         powerControlNext;
    logic [7:0]         rdataReg;
    logic [7:0]         rdataNext;
    logic               rvalidReg;
    logic               rvalidNext;

    // unused bits stored as written; they steer nothing, but software that
    // reads back after a write sees exactly what it wrote
    // a read in the same cycle as a write returns the old value
    always_comb begin
        powerControlNext = powerControlReg;
        rdataNext        = 8'h00;
        rvalidNext       = req.read;
        if (req.write && hitsReg(req.addr)) begin
            powerControlNext = req.wdata;
        end
        if (req.read && hitsReg(req.addr)) begin
            rdataNext = powerControlReg;
        end
    end

    always_ff @(posedge clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            powerControlReg <= pcs_pkg::POWER_CTRL_RESET;
            rdataReg        <= 8'h00;
            rvalidReg       <= 1'b0;
        end else begin
            powerControlReg <= powerControlNext;
            rdataReg        <= rdataNext;
            rvalidReg       <= rvalidNext;
        end
    end

    // ************************************************************
    // enable edge, channel latch and mode outputs
    // ************************************************************
    logic                         enPrevReg;
    logic                         enPrevNext;
    pcs_pkg::pcs_ctrl_s           ctrlReg;
    pcs_pkg::pcs_ctrl_s           ctrlNext;
    logic                         enRise;
    logic [pcs_pkg::CH_COUNT-1:0] selBits;
    logic                         skipBit;
    logic                         thresholdBit;

    // the edge detector resets low, matching the idle pin, so no false rise
    assign enRise = enSync && !enPrevReg;

    // field picks shared by the next-state logic and the assertions
    assign selBits      = powerControlReg[pcs_pkg::BIT_CH_FIRST +: pcs_pkg::CH_COUNT];
    assign skipBit      = powerControlReg[pcs_pkg::BIT_PULSE_SKIP];
    assign thresholdBit = powerControlReg[pcs_pkg::BIT_UVLO_SELECT];

    // channels latch on enable rise and drop when enable falls; a write while
    // the pin stays high waits for the next rise, so running rails never jump
    always_comb begin
        enPrevNext = enSync;
        ctrlNext   = ctrlReg;
        if (enRise) begin
            ctrlNext.chanEnable = selBits;
        end else if (!enSync) begin
            ctrlNext.chanEnable = '0;
        end
        ctrlNext.pulseSkipSelect                  = skipBit;
        ctrlNext.inputUndervoltageThresholdSelect = thresholdBit;
    end

    always_ff @(posedge clk or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            enPrevReg <= 1'b0;
            ctrlReg   <= '0;
        end else begin
            enPrevReg <= enPrevNext;
            ctrlReg   <= ctrlNext;
        end
    end

    assign rdata  = rdataReg;
    assign rvalid = rvalidReg;
    assign ctrl   = ctrlReg;

    // ************************************************************
    // assertions
    // ************************************************************
    // register contents after reset and after bus access
    a_reset_value: assert property (@(posedge clk)
        $rose(rstLocal_n) |-> powerControlReg == pcs_pkg::POWER_CTRL_RESET)
        else $error("register not at reset value");

    a_write_store: assert property (@(posedge clk) disable iff (!rstLocal_n)
        req.write && hitsReg(req.addr) |=> powerControlReg == $past(req.wdata))
        else $error("write not stored");

    a_other_addr: assert property (@(posedge clk) disable iff (!rstLocal_n)
        req.write && !hitsReg(req.addr) |=> $stable(powerControlReg))
        else $error("foreign write changed register");

    // read answer: one cycle late, zero when idle or unmapped
    a_read_back: assert property (@(posedge clk) disable iff (!rstLocal_n)
        req.read && hitsReg(req.addr) |=> rvalid && rdata == $past(powerControlReg))
        else $error("read data wrong");

    a_read_idle: assert property (@(posedge clk) disable iff (!rstLocal_n)
        !req.read |=> !rvalid && rdata == '0)
        else $error("read answer without request");

    a_read_unmapped: assert property (@(posedge clk) disable iff (!rstLocal_n)
        req.read && !hitsReg(req.addr) |=> rvalid && rdata == '0)
        else $error("unmapped read not zero");

    // channel enables: latch on rise, hold while high, clear when low
    a_chan_latch: assert property (@(posedge clk) disable iff (!rstLocal_n)
        enRise |=> ctrl.chanEnable == $past(selBits))
        else $error("channel enables wrong after rise");

    a_chan_hold: assert property (@(posedge clk) disable iff (!rstLocal_n)
        enSync && !enRise |=> $stable(ctrl.chanEnable))
        else $error("channel enables moved while pin high");

    a_chan_off: assert property (@(posedge clk) disable iff (!rstLocal_n)
        enRise && !selBits[0] |=> !ctrl.chanEnable[0] [*2])
        else $error("deselected channel enabled");

    a_chan_clear: assert property (@(posedge clk) disable iff (!rstLocal_n)
        !enSync |=> ctrl.chanEnable == '0)
        else $error("channels on with pin low");

    // mode copies; the first cycle after release still shows the reset zeros
    a_pulse_skip: assert property (@(posedge clk) disable iff (!rstLocal_n)
        $past(rstLocal_n) |-> ctrl.pulseSkipSelect == $past(skipBit))
        else $error("pulse skip mismatch");

    a_threshold_select: assert property (@(posedge clk) disable iff (!rstLocal_n)
        $past(rstLocal_n) |-> ctrl.inputUndervoltageThresholdSelect == $past(thresholdBit))
        else $error("threshold select mismatch");

    // main scenarios
    c_rise_all: cover property (@(posedge clk) disable iff (!rstLocal_n)
        enRise && selBits == 3'h7);
    c_rise_part: cover property (@(posedge clk) disable iff (!rstLocal_n)
        enRise && selBits == 3'h2);
    c_write_read: cover property (@(posedge clk) disable iff (!rstLocal_n)
        req.write && hitsReg(req.addr) ##1 req.read && hitsReg(req.addr));
    c_skip_off: cover property (@(posedge clk) disable iff (!rstLocal_n)
        $past(rstLocal_n) && !ctrl.pulseSkipSelect);
    c_threshold_low: cover property (@(posedge clk) disable iff (!rstLocal_n)
        $past(rstLocal_n) && !ctrl.inputUndervoltageThresholdSelect);
endmodule

// ==== hw/pcs_sync.sv ====
// two-flop synchroniser for a level arriving from outside the clock domain
module pcs_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic stage1Reg;
    logic stage1Next;
    logic stage2Reg;
    logic stage2Next;

    // first stage is read only by the second
    always_comb begin
        stage1Next = din;
        stage2Next = stage1Reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1Reg <= 1'b0;
            stage2Reg <= 1'b0;
        end else begin
            stage1Reg <= stage1Next;
            stage2Reg <= stage2Next;
        end
    end

    assign dout = stage2Reg;
endmodule

// ==== testbench/pcs_power_control_tb.sv ====
// testbench for the power control register: reset value, access, modes, channel latch
module pcs_power_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk;
    logic               rst_n;
    logic               enablePin;
    pcs_pkg::pcs_req_s  req;
    logic [7:0]         rdata;
    logic               rvalid;
    pcs_pkg::pcs_ctrl_s ctrl;
    int                 bad_count;
    int                 checked;
    logic [7:0]         got;

    pcs_power_control dut (
        .clk       (clk),
        .rst_n     (rst_n),
        .enablePin (enablePin),
        .req       (req),
        .rdata     (rdata),
        .rvalid    (rvalid),
        .ctrl      (ctrl)
    );

    // 10 MHz clock
    always #50 clk = ~clk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ctrl packs channels, pulse skip, threshold into five bits
    task automatic chkCtrl(input logic [2:0] chan, input logic skip, input logic thr);
        chk("controls", {3'h0, chan, skip, thr}, {3'h0, ctrl});
    endtask

    // one-cycle write strobe, then a free cycle so the next task never re-drives req at once
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        req = '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
        @(negedge clk);
        req.write = 1'b0;
        @(negedge clk);
    endtask

    // rvalid stands one cycle, so poll each falling edge with a bound
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        req = '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk);
        req.read = 1'b0;
        for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk);
        chk("read answer", 8'h01, {7'h00, rvalid});
        if (rvalid !== 1'b1) end_of_test();
        data = rdata;
        @(negedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chkCtrl(3'h0, 1'b1, 1'b1);
        rd(8'h0A, got);
        chk("reset value", 8'h7F, got);
    endtask

    // reset in mid-run restores the default, and all three channels relatch from it while the pin stays high
    task automatic t_midreset();
        wr(8'h0A, 8'h00);
        enablePin = 1'b1;
        repeat (4) @(negedge clk);
        chkCtrl(3'h0, 1'b0, 1'b0);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chkCtrl(3'h0, 1'b0, 1'b0);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chkCtrl(3'h0, 1'b1, 1'b1);
        repeat (3) @(negedge clk);
        chkCtrl(3'h7, 1'b1, 1'b1);
        rd(8'h0A, got);
        chk("value after reset", 8'h7F, got);
        enablePin = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // unused bits included: all eight bits must read back
    task automatic t_access();
        logic [7:0] vals [4] = '{8'hB5, 8'h4A, 8'h00, 8'hFF};
        foreach (vals[i]) begin
            wr(8'h0A, vals[i]);
            repeat (2) @(negedge clk);
            chkCtrl(3'h0, vals[i][3], vals[i][6]);
            rd(8'h0A, got);
            chk("readback", vals[i], got);
        end
    endtask

    task automatic t_unmapped();
        wr(8'h0B, 8'h00);
        rd(8'h0A, got);
        chk("after unmapped write", 8'hFF, got);
        rd(8'h0B, got);
        chk("unmapped read", 8'h00, got);
    endtask

    // every channel pattern; a write while the pin is high must not relatch
    task automatic t_enable();
        for (int i = 0; i < 8; i++) begin
            wr(8'h0A, 8'h48 | 8'(i));
            enablePin = 1'b1;
            repeat (4) @(negedge clk);
            chkCtrl(3'(i), 1'b1, 1'b1);
            wr(8'h0A, 8'h48 | 8'(~i & 7));
            repeat (3) @(negedge clk);
            chkCtrl(3'(i), 1'b1, 1'b1);
            enablePin = 1'b0;
            repeat (4) @(negedge clk);
            chkCtrl(3'h0, 1'b1, 1'b1);
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        enablePin = 1'b0;
        req = '0;
        bad_count = 0;
        checked = 0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_access();
        t_unmapped();
        t_enable();
        t_midreset();
        end_of_test();
    end

    // hang guard, far beyond the longest sequence
    initial begin
        repeat (5000) @(posedge clk);
        chk("run time", 8'h00, 8'h01);
        end_of_test();
    end
endmodule
